// [design/atm_rx_cell_performance_monitor_lcd.sv]
// Receive cell performance monitor and loss-of-delineation integrator.
// Assumes the delineator drives state and strobes synchronous to core_clk
// and that software reaches the registers over classic Wishbone.
//
// Overview of operation
// - Declare loss of delineation after out-of-delineation persists for the period.
// - Clear loss of delineation after SYNC persists for the same period.
// - Each change of loss state pulses the interrupt output when unmasked.
// - Period zero declares loss on any out-of-delineation within one clock.
// - One period count is 1 ms in E1 mode and 1.326 ms in T1.
// - Integration timing is counted on the block's own clock.
// - Trigger write copies assigned, uncorrectable and correctable counts to latches.
// - The same write restarts the live counters from that cycle's increments after capture.
// - Correctable count rises on single-bit errors in SYNC with correction active.
// - Correctable count holds while correction is disabled.
// - Uncorrectable count tallies uncorrectable header errors in SYNC since last latch.
// - SYNC-to-HUNT adds 1 and 5, or 6 uncorrectable without correction.
// - Loss follows the seventh bad header, so six errors per loss.
// - Outside SYNC only the SYNC-to-HUNT bulk addition and a trigger write move a counter.
// - Latched assigned count: high byte at 66h, low byte at 67h.
// - Latched uncorrectable count: bits 11..8 at 64h low nibble, low byte 65h.
// - Reads return the last latched value, never the live count.
// - Assigned count rises on every valid SYNC cell, dequeued or not.
`timescale 1ns/1ps
`default_nettype none
module atm_rx_cell_performance_monitor_lcd
	import rx_cellmon_pkg::*;
#(
	parameter int unsigned E1_TICK_CYCLES = E1_UNIT_CYC,
	parameter int unsigned T1_TICK_CYCLES = T1_UNIT_CYC
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// Wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [31:0]            wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic                        wb_ack_o,
	output logic [31:0]                 wb_dat_o,
	// Delineator side
	input  wire rx_cellmon_pkg::delin_state_e delin_state,
	input  wire rx_cellmon_pkg::cell_events_s cell_events,
	input  wire logic                   correction_mode,
	// Loss-of-delineation status
	output logic                        loss_of_delineation,
	output logic                        loss_change_irq
);
	import rx_cellmon_pkg::*;

	function automatic logic reg_hit(input logic [31:0] adr, input logic [6:0] idx);
		reg_hit = (adr[31:2] == {23'h0, idx});
	endfunction

	// Saturating add over the widest counter; caller cuts to width
	function automatic logic [ACC_W-1:0] sat_add(input logic [ACC_W-1:0] v,
			input logic [3:0] inc, input logic [ACC_W-1:0] max);
		logic [ACC_W:0] s;
		s = {1'b0, v} + {13'h0, inc};
		sat_add = (s > {1'b0, max}) ? max : s[ACC_W-1:0];
	endfunction

	localparam logic [ACC_W-1:0] CHC_MAX = {{(ACC_W-CHC_W){1'b0}}, {CHC_W{1'b1}}};
	localparam logic [ACC_W-1:0] UHC_MAX = {{(ACC_W-UHC_W){1'b0}}, {UHC_W{1'b1}}};
	localparam logic [ACC_W-1:0] ACC_MAX = {ACC_W{1'b1}};
	localparam logic [TICK_W-1:0] E1_TICK_LAST = TICK_W'(E1_TICK_CYCLES - 1);
	localparam logic [TICK_W-1:0] T1_TICK_LAST = TICK_W'(T1_TICK_CYCLES - 1);

	// Bus decode
	logic req;
	logic wr;
	logic [7:0] period_q;
	logic [2:0] ctrl_q;
	logic       ack_q;
	logic [31:0] rdata_q;
	logic [7:0] rd_byte;
	logic       latch_wr;

	assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr       = req & wb_we_i & wb_sel_i[0];
	assign latch_wr = wr & reg_hit(wb_adr_i, IDX_LATCH);
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// Live and latched counters
	logic [CHC_W-1:0] chc_live_q;
	logic [UHC_W-1:0] uhc_live_q;
	logic [ACC_W-1:0] acc_live_q;
	logic [CHC_W-1:0] chc_lat_q;
	logic [UHC_W-1:0] uhc_lat_q;
	logic [ACC_W-1:0] acc_lat_q;

	// Integrator state
	logic              loss_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic [7:0]        persist_q;
	logic              prev_sync_q;
	logic              irq_q;

	logic in_sync;
	logic out_of_delineation;
	logic loss_evt;
	logic corr_en;
	logic corr_active;
	logic cond;
	logic tick;
	logic loss_flip;
	logic [3:0] chc_inc;
	logic [3:0] uhc_inc;
	logic [3:0] acc_inc;

	assign in_sync     = (delin_state == SYNC);
	assign out_of_delineation = ~in_sync;
	assign loss_evt    = prev_sync_q & (delin_state == HUNT);
	assign corr_en     = ctrl_q[CTRL_CORR_BIT];
	assign corr_active = corr_en & correction_mode;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			period_q <= PERIOD_RST;
			ctrl_q   <= CTRL_RST;
		end else if (wr) begin
			if (reg_hit(wb_adr_i, IDX_PERIOD)) begin
				period_q <= wb_dat_i[7:0];
			end
			if (reg_hit(wb_adr_i, IDX_CTRL)) begin
				ctrl_q <= wb_dat_i[2:0];
			end
		end
	end

	// Counter reads only see latches, so a read never races a counting event
	always_comb begin
		rd_byte = 8'h00;
		if (reg_hit(wb_adr_i, IDX_PERIOD)) begin
			rd_byte = period_q;
		end else if (reg_hit(wb_adr_i, IDX_CHC)) begin
			rd_byte = chc_lat_q;
		end else if (reg_hit(wb_adr_i, IDX_UHC_HI)) begin
			rd_byte = {4'h0, uhc_lat_q[UHC_W-1:8]};
		end else if (reg_hit(wb_adr_i, IDX_UHC_LO)) begin
			rd_byte = uhc_lat_q[7:0];
		end else if (reg_hit(wb_adr_i, IDX_ACC_HI)) begin
			rd_byte = acc_lat_q[ACC_W-1:8];
		end else if (reg_hit(wb_adr_i, IDX_ACC_LO)) begin
			rd_byte = acc_lat_q[7:0];
		end else if (reg_hit(wb_adr_i, IDX_CTRL)) begin
			rd_byte = {5'h00, ctrl_q};
		end else if (reg_hit(wb_adr_i, IDX_STATUS)) begin
			rd_byte = {5'h00, delin_state, loss_q};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (req & ~wb_we_i) begin
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// Increments per cycle; the loss cycle already shows HUNT so no cell adds twice
	always_comb begin
		chc_inc = 4'h0;
		uhc_inc = 4'h0;
		acc_inc = 4'h0;
		if (in_sync) begin
			if (cell_events.cell_ok) begin
				acc_inc = ONE_INC;
			end
			if (cell_events.hec_single & corr_active) begin
				chc_inc = ONE_INC;
			end
			if (cell_events.hec_multi | (cell_events.hec_single & ~corr_active)) begin
				uhc_inc = ONE_INC;
			end
		end
		// Only six of the seven bad headers are booked per loss
		if (loss_evt) begin
			if (corr_en) begin
				chc_inc = LOSS_CORR_INC;
				uhc_inc = LOSS_UNC_CORR;
			end else begin
				uhc_inc = LOSS_UNC_NOCORR;
			end
		end
	end

	// A trigger write starts the new interval with this cycle's events
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chc_live_q <= '0;
			uhc_live_q <= '0;
			acc_live_q <= '0;
		end else if (latch_wr) begin
			chc_live_q <= CHC_W'(chc_inc);
			uhc_live_q <= UHC_W'(uhc_inc);
			acc_live_q <= ACC_W'(acc_inc);
		end else begin
			chc_live_q <= CHC_W'(sat_add(ACC_W'(chc_live_q), chc_inc, CHC_MAX));
			uhc_live_q <= UHC_W'(sat_add(ACC_W'(uhc_live_q), uhc_inc, UHC_MAX));
			acc_live_q <= sat_add(acc_live_q, acc_inc, ACC_MAX);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chc_lat_q <= '0;
			uhc_lat_q <= '0;
			acc_lat_q <= '0;
		end else if (latch_wr) begin
			chc_lat_q <= chc_live_q;
			uhc_lat_q <= uhc_live_q;
			acc_lat_q <= acc_live_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_sync_q <= 1'b0;
		end else begin
			prev_sync_q <= in_sync;
		end
	end

	// Integrator: cond is the condition that, held long enough, flips the state
	assign cond = loss_q ? in_sync : out_of_delineation;
	// At or beyond the end, so a mode switch mid-count cannot strand the base
	assign tick = (tick_cnt_q >= (ctrl_q[CTRL_E1_BIT] ? E1_TICK_LAST : T1_TICK_LAST));
	assign loss_flip = cond & ((period_q == 8'h00) |
			(tick & ((persist_q + 8'h01) == period_q)));

	// Millisecond base restarts with the condition, so persistence is continuous
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
			persist_q  <= 8'h00;
		end else if (!cond | loss_flip) begin
			tick_cnt_q <= '0;
			persist_q  <= 8'h00;
		end else if (tick) begin
			tick_cnt_q <= '0;
			persist_q  <= persist_q + 8'h01;
		end else begin
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loss_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			loss_q <= loss_q ^ loss_flip;
			irq_q  <= loss_flip & ctrl_q[CTRL_MASK_BIT];
		end
	end

	assign loss_of_delineation = loss_q;
	assign loss_change_irq     = irq_q;

	// Checks
	sequence s_loss_corr;
		prev_sync_q && delin_state == HUNT && corr_en && !latch_wr;
	endsequence

	sequence s_loss_nocorr;
		prev_sync_q && delin_state == HUNT && !corr_en && !latch_wr;
	endsequence

	// A plain counting cycle: in SYNC and no trigger write restarting the counts
	sequence s_count_cycle;
		in_sync && !latch_wr;
	endsequence

	a_zero_period_declare: assert property (@(posedge core_clk) disable iff (!rst_n)
		period_q == 8'h00 && !loss_q && out_of_delineation |=> loss_q)
		else $error("zero period did not declare loss at once");

	a_declare_needs_ood: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(loss_q) |-> $past(out_of_delineation) && ($past(period_q) == 8'h00 || $past(tick)))
		else $error("loss declared without out-of-delineation or tick");

	a_clear_needs_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(loss_q) |-> $past(in_sync) && ($past(period_q) == 8'h00 || $past(tick)))
		else $error("loss cleared without SYNC or tick");

	a_irq_on_change: assert property (@(posedge core_clk) disable iff (!rst_n)
		loss_change_irq == ($changed(loss_q) && $past(ctrl_q[CTRL_MASK_BIT])))
		else $error("interrupt pulse does not match state change and mask");

	a_latch_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
		latch_wr |=> acc_lat_q == $past(acc_live_q) && uhc_lat_q == $past(uhc_live_q)
			&& chc_lat_q == $past(chc_live_q) && acc_live_q <= ACC_W'(1))
		else $error("trigger write did not capture and clear");

	a_latch_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		!latch_wr |=> $stable(acc_lat_q) && $stable(uhc_lat_q) && $stable(chc_lat_q))
		else $error("latched count moved without a trigger write");

	a_frozen_out_sync: assert property (@(posedge core_clk) disable iff (!rst_n)
		!in_sync && !loss_evt && !latch_wr |=> $stable(acc_live_q) && $stable(chc_live_q))
		else $error("counter moved outside SYNC");

	a_corr_off_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!corr_en && !latch_wr |=> $stable(chc_live_q))
		else $error("correctable count moved with correction off");

	a_loss_bulk_corr: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_loss_corr ##0 (uhc_live_q < UHC_W'(4090)) |=>
			uhc_live_q == $past(uhc_live_q) + UHC_W'(5))
		else $error("loss with correction did not add five");

	a_loss_bulk_nocorr: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_loss_nocorr ##0 (uhc_live_q < UHC_W'(4089)) |=>
			uhc_live_q == $past(uhc_live_q) + UHC_W'(6))
		else $error("loss without correction did not add six");

	a_acc_saturates: assert property (@(posedge core_clk) disable iff (!rst_n)
		acc_live_q == ACC_MAX && !latch_wr |=> acc_live_q == ACC_MAX)
		else $error("assigned count wrapped");

	a_zero_period_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		period_q == 8'h00 && loss_q && in_sync |=> !loss_q)
		else $error("zero period did not clear loss at once");

	a_irq_masked_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ctrl_q[CTRL_MASK_BIT] |=> !loss_change_irq)
		else $error("interrupt pulsed while masked");

	a_acc_cell_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_count_cycle ##0 (cell_events.cell_ok && acc_live_q != ACC_MAX) |=>
			acc_live_q == $past(acc_live_q) + ACC_W'(1))
		else $error("valid SYNC cell not counted");

	a_chc_single_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_count_cycle ##0 (cell_events.hec_single && corr_active
			&& chc_live_q != CHC_W'(CHC_MAX)) |=> chc_live_q == $past(chc_live_q) + CHC_W'(1))
		else $error("correctable error not counted");

	a_uhc_err_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_count_cycle ##0 (cell_events.hec_multi && uhc_live_q != UHC_W'(UHC_MAX)) |=>
			uhc_live_q == $past(uhc_live_q) + UHC_W'(1))
		else $error("uncorrectable error not counted");

	a_chc_saturates: assert property (@(posedge core_clk) disable iff (!rst_n)
		chc_live_q == CHC_W'(CHC_MAX) && !latch_wr |=> chc_live_q == CHC_W'(CHC_MAX))
		else $error("correctable count wrapped");

	a_latch_restarts: assert property (@(posedge core_clk) disable iff (!rst_n)
		latch_wr |=> uhc_live_q <= UHC_W'(LOSS_UNC_NOCORR) && chc_live_q <= CHC_W'(LOSS_CORR_INC))
		else $error("trigger write did not restart the live counts");

	a_ack_after_req: assert property (@(posedge core_clk) disable iff (!rst_n)
		req |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");

	a_rdata_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("read data upper lanes not zero");

	a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// [design/rx_performance_monitor_pkg.sv]
// Constants, register map and carrier types for the receive cell monitor.
// Assumes a 125 MHz core clock and a 32-bit classic Wishbone register bus.
package rx_cellmon_pkg;

	// Clock and integration time base
	localparam int unsigned CLK_PERIOD_PS = 8000;
	localparam int unsigned E1_UNIT_PS    = 1000000000;
	localparam int unsigned T1_UNIT_PS    = 1326000000;
	localparam int unsigned E1_UNIT_CYC   = E1_UNIT_PS / CLK_PERIOD_PS;
	localparam int unsigned T1_UNIT_CYC   = T1_UNIT_PS / CLK_PERIOD_PS;
	localparam int unsigned TICK_W        = 18;

	// Counter widths
	localparam int unsigned CHC_W = 8;
	localparam int unsigned UHC_W = 12;
	localparam int unsigned ACC_W = 16;

	// Register indices; byte address is four times the index
	localparam logic [6:0] IDX_PERIOD  = 7'h61;
	localparam logic [6:0] IDX_LATCH   = 7'h62;
	localparam logic [6:0] IDX_CHC     = 7'h63;
	localparam logic [6:0] IDX_UHC_HI  = 7'h64;
	localparam logic [6:0] IDX_UHC_LO  = 7'h65;
	localparam logic [6:0] IDX_ACC_HI  = 7'h66;
	localparam logic [6:0] IDX_ACC_LO  = 7'h67;
	localparam logic [6:0] IDX_CTRL    = 7'h6B;
	localparam logic [6:0] IDX_STATUS  = 7'h6C;

	// Control register fields
	localparam int unsigned CTRL_E1_BIT   = 0;
	localparam int unsigned CTRL_CORR_BIT = 1;
	localparam int unsigned CTRL_MASK_BIT = 2;

	// Status register fields
	localparam int unsigned STAT_LOSS_BIT  = 0;
	localparam int unsigned STAT_STATE_LSB = 1;

	// Reset values
	localparam logic [7:0] PERIOD_RST = 8'h00;
	localparam logic [2:0] CTRL_RST   = 3'h0;

	// Bulk additions on a loss of delineation, and the single-event increment
	localparam logic [3:0] LOSS_CORR_INC   = 4'h1;
	localparam logic [3:0] LOSS_UNC_CORR   = 4'h5;
	localparam logic [3:0] LOSS_UNC_NOCORR = 4'h6;
	localparam logic [3:0] ONE_INC         = 4'h1;

	typedef enum logic [1:0] {HUNT, PRESYNC, SYNC} delin_state_e;

	// Per-cell strobes from the delineator, one cycle each
	typedef struct packed {
		logic cell_ok;
		logic hec_single;
		logic hec_multi;
	} cell_events_s;

endpackage

// [sim/delin_model.sv]
// Behavioural cell delineator facing the receive monitor.
// Assumes the bench hands it commands synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module delin_model
	import rx_cellmon_pkg::*;
(
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	// Commands from the bench
	input  wire rx_cellmon_pkg::delin_state_e st_cmd,
	input  wire rx_cellmon_pkg::cell_events_s ev_cmd,
	input  wire logic                      corr_cmd,
	input  wire logic                      slow,
	// Toward the monitor
	output var rx_cellmon_pkg::delin_state_e  delin_state,
	output var rx_cellmon_pkg::cell_events_s  cell_events,
	output var logic                       correction_mode
);
	logic gap_q;

	// Slow mode spaces cells to every other cycle, as a slow line would
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			delin_state <= HUNT;
			cell_events <= '0;
			correction_mode <= 1'b0;
			gap_q <= 1'b0;
		end else begin
			gap_q <= slow & ~gap_q;
			delin_state <= st_cmd;
			correction_mode <= corr_cmd;
			// A header is single- or multi-bit errored, never both
			cell_events <= (slow && gap_q) ? '0 : cell_events_s'(ev_cmd & {2'b11, ~ev_cmd.hec_single});
		end
	end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the receive cell monitor with a counting model.
// Assumes the delineator model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rx_cellmon_pkg::*;
	logic core_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, lost, irq;
	logic corr_cmd, slow, cmode;
	logic [31:0] wb_adr, wb_wd, wb_rd, r;
	logic [3:0] wb_sel;
	logic [7:0] ctrl_v, q;
	delin_state_e st_cmd, dst, prev;
	cell_events_s ev_cmd, cev;
	int fails, cmp_count, irq_n, acc, uhc, chc, l_acc, l_uhc, l_chc;

	atm_rx_cell_performance_monitor_lcd #(.E1_TICK_CYCLES(4), .T1_TICK_CYCLES(6)) atm_rx_cell_performance_monitor_lcd_i (
		.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd),
		.wb_ack_o(wb_ack), .wb_dat_o(wb_rd), .delin_state(dst), .cell_events(cev),
		.correction_mode(cmode), .loss_of_delineation(lost), .loss_change_irq(irq));
	delin_model delin_model_i (.core_clk(core_clk), .rst_n(rst_n), .st_cmd(st_cmd),
		.ev_cmd(ev_cmd), .corr_cmd(corr_cmd), .slow(slow), .delin_state(dst),
		.cell_events(cev), .correction_mode(cmode));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	function automatic int sat(input int v, input int m);
		return (v > m) ? m : v;
	endfunction

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Reference counters; a trigger write latches and restarts them
	always @(posedge core_clk or negedge rst_n) begin
		int a, u, c;
		if (!rst_n) begin
			{acc, uhc, chc, l_acc, l_uhc, l_chc, irq_n} = '0;
			prev = HUNT;
		end else begin
			a = 0;
			u = 0;
			c = 0;
			if (prev == SYNC && dst == HUNT) begin
				c = ctrl_v[1] ? 1 : 0;
				u = ctrl_v[1] ? 5 : 6;
			end else if (dst == SYNC) begin
				a = cev.cell_ok;
				if (cev.hec_single && ctrl_v[1] && cmode)
					c = 1;
				else if (cev.hec_single || cev.hec_multi)
					u = 1;
			end
			if (wb_cyc && wb_stb && wb_we && !wb_ack && wb_adr[8:2] == IDX_LATCH) begin
				{l_acc, l_uhc, l_chc} = {acc, uhc, chc};
				{acc, uhc, chc} = {a, u, c};
			end else begin
				acc = sat(acc + a, 65535);
				uhc = sat(uhc + u, 4095);
				chc = sat(chc + c, 255);
			end
			irq_n += irq;
			prev = dst;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [6:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {23'h0, idx, 2'h0};
		wb_wd <= {24'h0, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50)
			fails++;
		q = wb_rd[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic lchk(input bit lat);
		int e[5];
		if (lat)
			wb(1'b1, IDX_LATCH, 8'h00);
		e = '{l_chc, l_uhc >> 8, l_uhc & 255, l_acc >> 8, l_acc & 255};
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, 7'(IDX_CHC + i), 8'h00);
			chk(32'(q), e[i]);
		end
	endtask

	task automatic traffic(input int n);
		repeat (n) begin
			@(posedge core_clk);
			r = lfsr(r);
			st_cmd <= (r[7:0] < 8'h10) ? HUNT : ((r[7:0] < 8'h18) ? PRESYNC : SYNC);
			ev_cmd <= cell_events_s'(r[10:8]);
			corr_cmd <= r[11];
			slow <= r[12] & r[13];
		end
		@(posedge core_clk);
		ev_cmd <= '0;
		st_cmd <= SYNC;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#720000;
		fails++;
		close_out();
	end

	initial begin
		{rst_n, wb_cyc, wb_stb, wb_we, corr_cmd, slow} = '0;
		{wb_adr, wb_wd, ctrl_v, fails, cmp_count} = '0;
		wb_sel = 4'hF;
		st_cmd = HUNT;
		ev_cmd = '0;
		r = 32'hA033;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		lchk(0);
		wb(1'b1, IDX_PERIOD, 8'hA5);
		wb(1'b0, IDX_PERIOD, 8'h00);
		chk(32'(q), 32'hA5);
		wb(1'b0, 7'h70, 8'h00);
		chk(32'(q), 32'h0);
		for (int ph = 0; ph < 4; ph++) begin
			ctrl_v = ph[0] ? 8'h02 : 8'h00;
			wb(1'b1, IDX_CTRL, ctrl_v);
			traffic(400);
			lchk(1);
			traffic(40);
			lchk(0);
		end
		// A cell every cycle, long enough to pin the 16- and 8-bit counts at full scale
		ctrl_v = 8'h02;
		wb(1'b1, IDX_CTRL, ctrl_v);
		corr_cmd <= 1'b1;
		slow <= 1'b0;
		ev_cmd <= 3'b110;
		repeat (65600) @(posedge core_clk);
		ev_cmd <= '0;
		lchk(1);
		ctrl_v = 8'h05;
		wb(1'b1, IDX_CTRL, ctrl_v);
		wb(1'b0, IDX_CTRL, 8'h00);
		chk(32'(q), 32'h05);
		wb(1'b1, IDX_PERIOD, 8'h02);
		st_cmd <= HUNT;
		repeat (5) @(posedge core_clk);
		chk({31'h0, lost}, 32'h0);
		repeat (10) @(posedge core_clk);
		chk({31'h0, lost}, 32'h1);
		chk(irq_n, 32'h1);
		wb(1'b0, IDX_STATUS, 8'h00);
		chk(32'(q), 32'h01);
		st_cmd <= SYNC;
		repeat (5) @(posedge core_clk);
		chk({31'h0, lost}, 32'h1);
		repeat (10) @(posedge core_clk);
		chk({31'h0, lost}, 32'h0);
		chk(irq_n, 32'h2);
		ctrl_v = 8'h01;
		wb(1'b1, IDX_CTRL, ctrl_v);
		wb(1'b1, IDX_PERIOD, 8'h00);
		st_cmd <= HUNT;
		repeat (3) @(posedge core_clk);
		chk({31'h0, lost}, 32'h1);
		chk(irq_n, 32'h2);
		st_cmd <= SYNC;
		repeat (3) @(posedge core_clk);
		lchk(1);
		close_out();
	end
endmodule
`default_nettype wire
